// ==== design/adc_channel_sequencer.v ====
/*
  Channel sequencer for an eight channel sampling converter: sequence
  memory, program and readback through pin strobes, direct, scan and run
  addressing, conversion timing and a small Wishbone register view.
  Assumes all pins are synchronous to clk_i and the converter core takes
  the conversion address and configuration and returns a result word.
*/
// Implementation choices: the Wishbone slave port and the register offsets.
// Operation
// - Sixteen entries of address and configuration
// - Seven bit word with end flag
// - Program mode drives busy low, no conversions
// - Any mode pin change resets pointer
// - Write strobe rise stores and advances
// - Last written entry gets end flag
// - Sixteen writes wrap pointer, new sequence
// - Readback drives word on upper pins
// - Lower data pins float during readback
// - Read strobe rise floats pins, advances
// - Low bit marks final entry, all readable
// - Sixteen reads wrap pointer to zero
// - Leaving program mode raises busy again
// - First run conversion uses entry zero
// - Run advances pointer, outputs real address
// - After final entry pointer returns zero
// - Contents kept across modes and shutdown
// - Mode pins select four modes
// - Direct and scan latch pin configuration
// - Start edge begins uninterruptible conversion
`timescale 1ns/100ps
`include "seq_defines.vh"

module adc_channel_sequencer
(
  // Clock, reset, enable
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // Mode and strobes
  input  wire        mode_pin_upper_i,
  input  wire        mode_pin_lower_i,
  input  wire        wr_n_i,
  input  wire        rd_n_i,
  input  wire        conversion_start_n_i,
  input  wire        chip_select_n_i,
  // Configuration inputs
  input  wire        pair_input_select_i,
  input  wire [2:0]  mux_address_in_i,
  input  wire        polarity_select_i,
  input  wire        gain_range_select_i,
  // Converter core
  output reg  [5:0]  conv_cfg_o,
  output wire        conv_start_o,
  input  wire [11:0] conv_result_i,
  // Status and data pins
  output wire        busy_n_o,
  output reg  [3:0]  addr_out_o,
  output reg  [11:0] data_o,
  output wire [11:0] data_oe_o,
  output wire [3:0]  addr_oe_o,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // Conversion timing states, one-hot.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // Sequence pointer and the record of the final programmed entry.
  reg [`SEQ_PTR_W-1:0]  ptr;
  reg [`SEQ_PTR_W-1:0]  next_ptr;
  reg [`SEQ_PTR_W-1:0]  last_written;
  reg                   wrote_any;

  // Previous samples of the mode pins and strobes, for edge detection.
  reg [1:0]             mode_q;
  reg                   wr_q;
  reg                   rd_q;
  reg                   cs_q;

  // Configuration latched for direct and scan modes, and the scan counter.
  reg [`SEQ_CFG_W-1:0]  held_cfg;
  reg [2:0]             scan_cnt;

  // Conversion timing, readback state and the software view.
  reg [2:0]             state;
  reg [`CONV_CNT_W-1:0] conv_cnt;
  reg                   reading;
  reg                   sw_hold;
  reg [15:0]            conv_count;

  // Stored configuration of each entry, read through the pointer.
  wire [`SEQ_CFG_W-1:0] entry_cfg [0:`SEQ_DEPTH-1];
  wire [`SEQ_CFG_W-1:0] ptr_cfg;

  wire [1:0]            mode     = {mode_pin_upper_i, mode_pin_lower_i};
  wire                  mode_chg = (mode != mode_q);
  wire                  in_prog  = (mode == `MODE_PROG);
  wire                  in_run   = (mode == `MODE_RUN);
  wire                  in_scan  = (mode == `MODE_SCAN);

  // Strobe edges are seen in the same cycle the level changes at the pin.
  wire                  wr_rise  = wr_n_i & ~wr_q;
  wire                  rd_fall  = ~rd_n_i & rd_q;
  wire                  rd_rise  = rd_n_i & ~rd_q;
  wire                  cs_fall  = ~conversion_start_n_i & cs_q;

  wire [`SEQ_CFG_W-1:0] pin_cfg  = {pair_input_select_i, mux_address_in_i,
                                    polarity_select_i, gain_range_select_i};

  wire                  ptr_is_end = wrote_any && (ptr == last_written);

  // A mode change in the same cycle wins over a strobe, so an access that
  // overlaps the pin toggle is dropped rather than landing in a stale entry.
  // write strobe store
  wire                  store_en   = in_prog && !mode_chg && wr_rise && rd_n_i;
  wire                  read_start = in_prog && !mode_chg && rd_fall && wr_n_i;
  wire                  read_end   = in_prog && !mode_chg && rd_rise && reading;

  wire                  idle       = (state == ST_IDLE);
  wire                  conv_last  = (conv_cnt == `CONV_CYCLES - 1);
  wire [2:0]            scan_step  = pair_input_select_i ? `SCAN_STEP_PAIR
                                                         : `SCAN_STEP_SINGLE;

  wire                  start_ok   = cs_fall && !chip_select_n_i && idle && !sw_hold;
  assign conv_start_o = start_ok && !in_prog && ce_i;

  assign busy_n_o  = !in_prog && idle;

  // The lower data pins stay released for the whole program session, so a
  // host that shares the data bus sees only the readback lanes driven.
  // lower pins float
  assign data_oe_o = reading ? `OE_READBACK
                             : (in_prog ? `OE_NONE : {`SEQ_DATA_W{idle}});
  assign addr_oe_o = 4'hF;

  assign ptr_cfg   = entry_cfg[ptr];

  // sixteen stored entries
  // The end flag is not stored: it is derived from last_written, so a later
  // program session that ends earlier moves the end without rewriting entries.
  genvar g;
  generate
    for (g = 0; g < `SEQ_DEPTH; g = g + 1)
    begin : entry_g
      reg [`SEQ_CFG_W-1:0] cfg_q;
      always @(posedge clk_i)
      begin
        if (ce_i && store_en && ptr == g)
          cfg_q <= pin_cfg;
      end
      assign entry_cfg[g] = cfg_q;
    end
  endgenerate

  always @*
  begin
    conv_cfg_o = ptr_cfg;
    case (mode)
      `MODE_DIRECT:
        conv_cfg_o = wr_n_i ? held_cfg : pin_cfg;
      `MODE_SCAN:
      begin
        conv_cfg_o = wr_n_i ? held_cfg : pin_cfg;
        conv_cfg_o[`CFG_ADDR_HI:`CFG_ADDR_LO] = scan_cnt;
      end
      default:
        conv_cfg_o = ptr_cfg;
    endcase
  end

  always @*
  begin
    if (ptr_is_end)
      next_ptr = `SEQ_PTR_ZERO;
    else
      next_ptr = ptr + 4'h1;
  end

  // Edge history. Strobe samples reset to the idle high level so that no
  // false edge follows reset.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q <= `MODE_DIRECT;
      wr_q   <= 1'b1;
      rd_q   <= 1'b1;
      cs_q   <= 1'b1;
    end
    else if (ce_i)
    begin
      mode_q <= mode;
      wr_q   <= wr_n_i;
      rd_q   <= rd_n_i;
      cs_q   <= conversion_start_n_i;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      held_cfg <= 6'h00;
    else if (ce_i)
    begin
      if (wr_rise || (cs_fall && !in_prog))
        held_cfg <= pin_cfg;
    end
  end

  // Scan counter steps by two in pair mode, so from zero it names only even channels.
  always @(posedge clk_i)
  begin
    if (rst_i)
      scan_cnt <= `SCAN_ZERO;
    else if (ce_i)
    begin
      if (mode_chg)
        scan_cnt <= `SCAN_ZERO;
      else if (conv_start_o && in_scan)
        scan_cnt <= scan_cnt + scan_step;
    end
  end

  // Pointer. One process owns it, so write, read and run advance cannot race.
  always @(posedge clk_i)
  begin
    if (rst_i)
      ptr <= `SEQ_PTR_ZERO;
    else if (ce_i)
    begin
      if (mode_chg)
        ptr <= `SEQ_PTR_ZERO;
      else if (store_en || read_end)
        ptr <= ptr + 4'h1;
      else if (conv_start_o && in_run)
        ptr <= next_ptr;
    end
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      last_written <= `SEQ_PTR_LAST;
      wrote_any    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (store_en)
      begin
        last_written <= ptr;
        wrote_any    <= 1'b1;
      end
    end
  end

  // Readback session flag; it also gates the readback output enables.
  always @(posedge clk_i)
  begin
    if (rst_i)
      reading <= 1'b0;
    else if (ce_i)
    begin
      if (mode_chg)
        reading <= 1'b0;
      else if (read_start)
        reading <= 1'b1;
      else if (read_end)
        reading <= 1'b0;
    end
  end

  // Conversion timing and the output registers. Readback and conversion
  // results share the data and address pins, so both are written here.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= ST_IDLE;
      conv_cnt   <= {`CONV_CNT_W{1'b0}};
      addr_out_o <= 4'h0;
      data_o     <= 12'h000;
      conv_count <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (read_start)
      begin
        addr_out_o <= ptr_cfg[`CFG_PAIR_BIT:`CFG_CHAN_LO];
        data_o     <= {ptr_cfg[`CFG_POL_BIT:`CFG_GAIN_BIT], ptr_is_end, `READBACK_PAD};
      end
      case (state)
        ST_IDLE:
        begin
          if (conv_start_o)
          begin
            state    <= ST_CONV;
            conv_cnt <= {`CONV_CNT_W{1'b0}};
            addr_out_o <= conv_cfg_o[`CFG_PAIR_BIT:`CFG_CHAN_LO];
          end
        end
        ST_CONV:
        begin
          if (conv_last)
            state <= ST_DONE;
          else
            conv_cnt <= conv_cnt + 8'h01;
        end
        ST_DONE:
        begin
          data_o     <= conv_result_i;
          conv_count <= conv_count + 16'h0001;
          state      <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Wishbone view: control hold bit, status and last result; single-cycle
  // ack. It keeps running while ce_i is low so software can still look in.
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      sw_hold  <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      begin
        if (wb_adr_i == `REG_CTRL)
        begin
          if (wb_we_i && wb_sel_i[0])
            sw_hold <= wb_dat_i[`CTRL_HOLD_BIT];
          wb_dat_o <= {31'h0, sw_hold};
        end
        else if (wb_adr_i == `REG_STATUS)
          wb_dat_o <= {16'h0, conv_count[7:0], ptr, wrote_any, state};
        else if (wb_adr_i == `REG_RESULT)
          wb_dat_o <= {16'h0, addr_out_o, data_o};
        else
          wb_dat_o <= 32'h00000000;
      end
    end
  end

endmodule

// ==== shared/seq_defines.vh ====
/*
  Constants for the channel sequencer: memory geometry, mode codes,
  readback word layout, conversion timing and register map.
  Assumes inclusion by bare name from design files.
*/
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH

`define SEQ_DEPTH        16
`define SEQ_PTR_W        4
`define SEQ_PTR_ZERO     4'h0
`define SEQ_PTR_LAST     4'hF
`define SEQ_CFG_W        6
`define SEQ_WORD_W       7
`define SEQ_DATA_W       12

`define MODE_DIRECT      2'h0
`define MODE_SCAN        2'h1
`define MODE_PROG        2'h2
`define MODE_RUN         2'h3

`define CFG_PAIR_BIT     5
`define CFG_ADDR_HI      4
`define CFG_ADDR_LO      2
`define CFG_POL_BIT      1
`define CFG_GAIN_BIT     0
`define CFG_CHAN_LO      2

`define READBACK_PAD     9'h000
`define OE_READBACK      12'hE00
`define OE_NONE          12'h000
`define SCAN_STEP_PAIR   3'h2
`define SCAN_STEP_SINGLE 3'h1
`define SCAN_ZERO        3'h0
`define CTRL_HOLD_BIT    0

`define CONV_TIME_NS     650
`define CLK_PERIOD_NS    4
`define CONV_CYCLES      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CNT_W       8

`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_RESULT       4'h8
`define CTRL_RESET       2'h0

`endif

// ==== dv/conv_core_model.sv ====
/* Converter core stand-in for the sequencer.
   Assumes one clock shared with the sequencer. */
`timescale 1ns/100ps
module conv_core_model (
  // Clock
  input  wire        clk_i,
  // Core side
  input  wire        conv_start_i,
  input  wire [5:0]  conv_cfg_i,
  output reg  [11:0] conv_result_o
);
  // The result carries the configuration, so a wrong entry shows up.
  initial conv_result_o = 12'hAAA;
  always @(posedge clk_i)
    if (conv_start_i)
      conv_result_o <= {6'h15, conv_cfg_i};
endmodule

// ==== dv/adc_channel_sequencer_monitor.sv ====
/* Port checker for the sequencer.
   Assumes it is bound to the sequencer top. */
`timescale 1ns/100ps
module adc_channel_sequencer_monitor (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Host pins
  input wire        mode_pin_upper_i,
  input wire        mode_pin_lower_i,
  input wire        rd_n_i,
  input wire        chip_select_n_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  // Outputs
  input wire        conv_start_o,
  input wire        busy_n_o,
  input wire [11:0] data_oe_o,
  input wire        wb_ack_o
);
  wire prog = mode_pin_upper_i && !mode_pin_lower_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_busy; prog ##1 prog |-> !busy_n_o; endproperty
  a_busy: assert property (p_busy) else $error("busy in program mode");
  property p_nostart; prog ##1 prog |-> !conv_start_o; endproperty
  a_nostart: assert property (p_nostart) else $error("start in program mode");
  property p_low; conv_start_o |=> (!busy_n_o)[*8]; endproperty
  a_low: assert property (p_low) else $error("busy not low");
  property p_once; conv_start_o |=> (!conv_start_o)[*8]; endproperty
  a_once: assert property (p_once) else $error("restart");
  property p_done; conv_start_o |-> ##[160:170] $rose(busy_n_o); endproperty
  a_done: assert property (p_done) else $error("no completion");
  property p_sel; conv_start_o |-> !chip_select_n_i; endproperty
  a_sel: assert property (p_sel) else $error("start unselected");
  property p_float; (prog && rd_n_i)[*3] |-> data_oe_o == 12'h000; endproperty
  a_float: assert property (p_float) else $error("pins driven");
  property p_pins; (prog && !rd_n_i)[*3] |-> data_oe_o == 12'hE00; endproperty
  a_pins: assert property (p_pins) else $error("readback pins");
  property p_ack; $rose(wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
endmodule
bind adc_channel_sequencer adc_channel_sequencer_monitor mon_u (.*);

// ==== dv/adc_channel_sequencer_bench.sv ====
/* Self-checking bench for the sequencer.
   Assumes design, checker and core model compiled first. */
`timescale 1ns/100ps
module adc_channel_sequencer_bench;
  reg clk_i = 0, rst_i = 1, ce_i = 1, chip_select_n_i = 0, rd_n_i = 1;
  reg mode_pin_upper_i = 1, mode_pin_lower_i = 1, wr_n_i = 1;
  reg conversion_start_n_i = 1, pair_input_select_i = 0;
  reg polarity_select_i = 0, gain_range_select_i = 0;
  reg [2:0] mux_address_in_i = 3'h0;
  reg wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0, rdata;
  wire [5:0] conv_cfg_o;
  wire conv_start_o, busy_n_o, wb_ack_o;
  wire [11:0] conv_result_i, data_o, data_oe_o;
  wire [3:0] addr_out_o, addr_oe_o;
  wire [31:0] wb_dat_o;
  integer n_errors = 0, cmp_count = 0, i;
  adc_channel_sequencer dut_u (.*);
  conv_core_model core_u (.clk_i(clk_i), .conv_start_i(conv_start_o),
    .conv_cfg_i(conv_cfg_o), .conv_result_o(conv_result_i));
  initial forever #2 clk_i = ~clk_i;
  // Nineteen writes wrap, so entries 0 to 2 hold writes 16 to 18.
  function [5:0] entry(input integer k);
    entry = (k < 3) ? (k + 16) * 7 + 3 : k * 7 + 3;
  endfunction
  task give_verdict;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task cmp(input [63:0] what, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("mismatch %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task set_mode(input [1:0] m);
    begin
      @(posedge clk_i);
      {mode_pin_upper_i, mode_pin_lower_i} <= m;
      tick(3);
    end
  endtask
  // Pulses write strobe (which 0) or conversion start (which 1) low.
  task pulse(input integer which, input integer n);
    begin
      @(posedge clk_i);
      if (which == 0)
        wr_n_i <= 0;
      else
        conversion_start_n_i <= 0;
      tick(n);
      if (which == 0)
        wr_n_i <= 1;
      else
        conversion_start_n_i <= 1;
      tick(3);
    end
  endtask
  task wb(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
        @(posedge clk_i);
      rdata = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
    end
  endtask
  task t_program;
    begin
      set_mode(2'h3);
      set_mode(2'h2);
      pulse(1, 3);
      cmp("busy", 1'b0, busy_n_o);
      for (i = 0; i < 19; i = i + 1)
      begin
        {pair_input_select_i, mux_address_in_i, polarity_select_i, gain_range_select_i}
          <= i * 7 + 3;
        pulse(0, 2);
      end
    end
  endtask
  task t_readback;
    begin
      set_mode(2'h3);
      set_mode(2'h2);
      for (i = 0; i < 17; i = i + 1)
      begin
        @(posedge clk_i);
        rd_n_i <= 0;
        tick(3);
        cmp("word", {entry(i % 16), i % 16 == 2}, {addr_out_o, data_o[11:9]});
        cmp("oe", 12'hE00, data_oe_o);
        rd_n_i <= 1;
        tick(3);
        cmp("oe", 12'h000, data_oe_o);
      end
    end
  endtask
  task t_wb;
    begin
      set_mode(2'h3);
      cmp("busy", 1'b1, busy_n_o);
      wb(1'b0, 4'hC, 32'h0);
      cmp("wbdata", 32'h0, rdata);
      wb(1'b1, 4'h0, 32'h1);
      wb(1'b0, 4'h0, 32'h0);
      cmp("ctrl", 32'h1, rdata);
      pulse(1, 5);
      cmp("busy", 1'b1, busy_n_o);
      wb(1'b1, 4'h0, 32'h0);
    end
  endtask
  task conv(input [5:0] c);
    begin
      @(posedge clk_i);
      conversion_start_n_i <= 0;
      @(posedge clk_i);
      while (conv_start_o !== 1'b1)
        @(posedge clk_i);
      cmp("cfg", c, conv_cfg_o);
      conversion_start_n_i <= 1;
      tick(2);
      while (busy_n_o !== 1'b1)
        @(posedge clk_i);
      tick(2);
      cmp("chan", c[5:2], addr_out_o);
      cmp("result", {6'h15, c}, data_o);
    end
  endtask
  task t_run;
    begin
      for (i = 0; i < 4; i = i + 1)
        conv(entry(i % 3));
      set_mode(2'h0);
      set_mode(2'h3);
      conv(entry(0));
    end
  endtask
  initial
  begin
    tick(20);
    rst_i <= 0;
    tick(1);
    t_program;
    t_readback;
    t_wb;
    t_run;
    give_verdict;
  end
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule
